// ===== testbench/ems_top_sva.sv
// Purpose: port-level checks of the supervisor
// Assumes: one clock, rst_b active low
// Notes:   bound into every ems_top
`timescale 1ns/1ps
module ems_top_sva import ems_pkg::*; #(
   parameter int unsigned SEC_CYCLES = 20
) (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [3:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [1:0]  drive_state,
   input wire logic        run_cmd,
   input wire logic [5:0]  din,
   input wire logic [15:0] cmd_bits,
   input wire logic [3:0]  channel_warning_flag,
   input wire logic [3:0]  channel_error_flag,
   input wire logic        stop_req,
   input wire logic [2:0]  stop_kind,
   input wire logic        fallback_req,
   input wire logic [15:0] fallback_speed,
   input wire logic        hold_req
);
   // error bits that no write-one-clear touches this cycle
   logic [3:0] keep_err;
   assign keep_err = channel_error_flag & ~((reg_wr && reg_addr == 4'h5) ? reg_wdata[3:0] : 4'h0);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not idle");
   AST_RD_HOLE: assert property (reg_rd && reg_addr == 4'h7 |=>
      reg_rdata == 32'h0) else $error("unmapped read not zero");
   AST_RD_FB: assert property (reg_rd && reg_addr == 4'h6 |=>
      reg_rdata[15:0] == $past(fallback_speed)) else $error("fallback speed readback");
   AST_RD_STAT: assert property (reg_rd && reg_addr == 4'h5 |=>
      reg_rdata[7:0] == {$past(channel_warning_flag), $past(channel_error_flag)})
      else $error("status readback");
   AST_STOP_KIND: assert property (stop_req |-> stop_kind inside {[3'h1:3'h4]})
      else $error("stop without kind");
   AST_PRIO_STOP: assert property (stop_req |-> !fallback_req && !hold_req)
      else $error("stop beside speed request");
   AST_PRIO_FB: assert property (fallback_req |-> !hold_req)
      else $error("fallback beside hold");
   AST_RUN_DROP: assert property ((!run_cmd) [*3] |-> !fallback_req && !hold_req)
      else $error("speed request without run");
   AST_ERR_STICKY: assert property (keep_err != 4'h0 |=>
      (channel_error_flag & $past(keep_err)) == $past(keep_err)) else $error("error lost");
   AST_ERR_STOP: assert property ((channel_error_flag != 4'h0) [*2] |-> stop_req)
      else $error("error without stop");
endmodule // ems_top_sva
bind ems_top ems_top_sva #(.SEC_CYCLES(SEC_CYCLES)) u_sva (
   .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drive_state(drive_state),
   .run_cmd(run_cmd), .din(din), .cmd_bits(cmd_bits),
   .channel_warning_flag(channel_warning_flag), .channel_error_flag(channel_error_flag),
   .stop_req(stop_req), .stop_kind(stop_kind), .fallback_req(fallback_req),
   .fallback_speed(fallback_speed), .hold_req(hold_req));

// ===== testbench/tb_top.sv
// Purpose: self-checking bench of the supervisor
// Assumes: one second shortened to SEC clocks
// Notes:   waits include sync and tick slack
`timescale 1ns/1ps
module tb_top import ems_pkg::*;;
   localparam int unsigned SEC = 20;
   logic        clk;
   logic        rst_b;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [1:0]  drive_state;
   logic        run_cmd;
   logic [5:0]  din;
   logic [15:0] cmd_bits;
   logic [3:0]  warn;
   logic [3:0]  err;
   logic        stop_req;
   logic [2:0]  stop_kind;
   logic        fb_req;
   logic [15:0] fb_spd;
   logic        hold_req;
   int          err_count;
   int          n_compared;
   int          cycles;

   ems_top #(.SEC_CYCLES(SEC)) i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .drive_state(drive_state), .run_cmd(run_cmd), .din(din), .cmd_bits(cmd_bits),
      .channel_warning_flag(warn), .channel_error_flag(err), .stop_req(stop_req),
      .stop_kind(stop_kind), .fallback_req(fb_req), .fallback_speed(fb_spd),
      .hold_req(hold_req));

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic go(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string m);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp, m);
   endtask

   function automatic logic [31:0] cw(logic [5:0] s, logic [1:0] g, logic [2:0] r, logic [8:0] d);
      return {7'h00, d, 1'h0, r, 2'h0, g, 2'h0, s};
   endfunction

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_regs;
      rd(4'h4, 32'h1, "ctrl reset");
      rd(4'h6, 32'h0, "fbspd reset");
      rd(4'h7, 32'h0, "unmapped");
      wr(4'h1, cw(6'h00, 2'h2, 3'h5, 9'h005));
      rd(4'h1, 32'h0, "unassigned hidden");
      wr(4'h0, 32'h00000010);
      // select and fields land together: zero fields mean ignore, 0 s
      rd(4'h0, cw(6'h10, 2'h0, 3'h0, 9'h000), "assigned fields");
      wr(4'h0, cw(6'h10, 2'h0, 3'h0, 9'h1FF));
      rd(4'h0, cw(6'h10, 2'h0, 3'h0, 9'h12C), "delay clamp");
      wr(4'h0, 32'h0);
      cmd_bits <= 16'hFFFF;
      din <= 6'h00;
      go(8);
      chk({warn, err, stop_req, fb_req, hold_req}, 32'h0, "unassigned quiet");
      cmd_bits <= 16'h0;
      din <= 6'h3F;
      go(6);
      $display("test regs done");
   endtask

   task automatic t_resp;
      logic [1:0] ch;
      logic [3:0] m;
      logic [11:0] e;
      wr(4'h4, 32'h2);
      rd(4'h4, 32'h2, "stop kind setting");
      wr(4'h6, 32'h00001234);
      for (int r = 0; r < 8; r++) begin
         ch = 2'(r);
         m = 4'h1 << ch;
         case (r)
            0: e = {4'h0, 1'b0, 3'h0, 1'b0, 1'b0, 2'h0};
            2: e = {4'h0, 1'b1, 3'h2, 1'b0, 1'b0, 2'h0};
            3: e = {4'h0, 1'b0, 3'h0, 1'b1, 1'b0, 2'h0};
            4: e = {4'h0, 1'b0, 3'h0, 1'b0, 1'b1, 2'h0};
            5: e = {m, 1'b1, 3'h1, 1'b0, 1'b0, 2'h0};
            6: e = {m, 1'b1, 3'h2, 1'b0, 1'b0, 2'h0};
            7: e = {m, 1'b1, 3'h4, 1'b0, 1'b0, 2'h0};
            default: e = {m, 1'b1, 3'h3, 1'b0, 1'b0, 2'h0};
         endcase
         wr({2'h0, ch}, cw(6'h10 + 6'(r), 2'h0, 3'(r), 9'h000));
         cmd_bits <= 16'h1 << r;
         go(6);
         chk(err, e[11:8], "error flag");
         chk({stop_req, stop_kind}, e[7:4], "stop");
         chk({fb_req, hold_req}, e[3:2], "speed keep");
         if (r == 0 || r == 2) chk(warn, r == 0 ? m : 4'h0, "warning");
         if (r == 3) chk(fb_spd, 32'h1234, "fallback speed");
         if (r == 3 || r == 4) begin
            run_cmd <= 1'b0;
            go(5);
            chk({fb_req, hold_req}, 32'h0, "run removed");
            run_cmd <= 1'b1;
         end
         cmd_bits <= 16'h0;
         wr(4'h5, 32'h0000000F);
         go(5);
         chk({err, warn, stop_req, fb_req, hold_req}, 32'h0, "released");
         wr({2'h0, ch}, 32'h0);
      end
      $display("test responses done");
   endtask

   task automatic t_gate;
      logic e;
      wr(4'h0, cw(6'h10, 2'h0, 3'h0, 9'h000));
      cmd_bits <= 16'h0001;
      // gating code 3 has no meaning and acts as always
      for (int g = 0; g < 4; g++) begin
         wr(4'h0, cw(6'h10, 2'(g), 3'h0, 9'h000));
         for (int s = 0; s < 4; s++) begin
            drive_state <= 2'(s);
            e = g == 0 || g == 3 || (g == 1 && (s == 1 || s == 2)) || (g == 2 && s == 2);
            go(5);
            chk(warn, {3'h0, e}, "gating");
         end
      end
      cmd_bits <= 16'h0;
      drive_state <= 2'h2;
      wr(4'h0, 32'h0);
      $display("test gating done");
   endtask

   task automatic t_delay;
      wr(4'h2, cw(6'h08, 2'h0, 3'h0, 9'h002));
      go(2);
      din <= 6'h3D;
      go(15);
      chk(warn, 32'h0, "early");
      go(4);
      din <= 6'h3F;
      go(2);
      din <= 6'h3D;
      // a count kept from the cut wait would fire on the next tick
      go(29);
      chk(warn, 32'h0, "count not cleared");
      rd(4'hA, 32'h80000001, "timer waiting");
      go(33);
      chk(warn, 32'h4, "after delay");
      din <= 6'h3F;
      go(6);
      chk(warn, 32'h0, "input released");
      wr(4'h2, 32'h0);
      wr(4'h3, cw(6'h06, 2'h0, 3'h0, 9'h000));
      go(6);
      chk(warn, 32'h8, "high level");
      din <= 6'h1F;
      go(6);
      chk(warn, 32'h0, "high released");
      din <= 6'h3F;
      wr(4'h3, 32'h0);
      $display("test delay done");
   endtask

   // ****************************************************************
   // run
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         $display("BAD %0t run hung", $time);
         results();
      end
   end

   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd, cmd_bits, cycles} = '0;
      {err_count, n_compared} = '0;
      rst_b = 1'b0;
      drive_state = 2'h2;
      run_cmd = 1'b1;
      din = 6'h3F;
      go(5);
      rst_b <= 1'b1;
      go(3);
      t_regs();
      t_resp();
      t_gate();
      t_delay();
      results();
   end
endmodule // tb_top

// ===== verilog/ems_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the supervisor
// Assumes: included by bare name wherever a constant is needed
// Notes:   definitions only
`ifndef EMS_CFG_SVH
`define EMS_CFG_SVH

// ****************************************************************
// timing
// ****************************************************************
`define EMS_CLK_HZ        200000000
`define EMS_STEP_S        1
`define EMS_DLY_MAX_S     9'h12C
`define EMS_DLY_RST       9'h000

// ****************************************************************
// register offsets
// ****************************************************************
`define EMS_OFF_CHAN      4'h0
`define EMS_OFF_CTRL      4'h4
`define EMS_OFF_STAT      4'h5
`define EMS_OFF_FBSPD     4'h6
`define EMS_OFF_TIMER     4'h8

// ****************************************************************
// channel, timer and status word fields
// ****************************************************************
`define EMS_F_SEL_LSB     0
`define EMS_F_GATE_LSB    8
`define EMS_F_RESP_LSB    12
`define EMS_F_DLY_LSB     16
`define EMS_F_WAIT_BIT    31
`define EMS_ST_WARN_LSB   4
`define EMS_ST_ACT_LSB    8

// ****************************************************************
// input select codes and reset values
// ****************************************************************
`define EMS_SEL_NONE      6'h00
`define EMS_SEL_DIH_LO    6'h01
`define EMS_SEL_DIH_HI    6'h06
`define EMS_SEL_DIL_LO    6'h07
`define EMS_SEL_DIL_HI    6'h0C
`define EMS_SEL_CMD_LO    6'h10
`define EMS_GATE_RST      2'h0
`define EMS_RESP_RST      3'h1
`define EMS_STOPK_RST     3'h1
`define EMS_FBSPD_RST     16'h0000

`endif

// ===== verilog/ems_pkg.sv
// Purpose: shared types of the external monitor supervisor
// Assumes: codes are the software-visible encodings
// Notes:   numbers live in ems_cfg.svh
package ems_pkg;

   typedef enum logic [1:0] {
      EMS_GATE_ALWAYS    = 2'h0,
      EMS_GATE_READY_RUN = 2'h1,
      EMS_GATE_RUN       = 2'h2
   } ems_gate_t;

   typedef enum logic [2:0] {
      EMS_RESP_IGNORE    = 3'h0,
      EMS_RESP_FREEWHEEL = 3'h1,
      EMS_RESP_PER_STOP  = 3'h2,
      EMS_RESP_FALLBACK  = 3'h3,
      EMS_RESP_HOLD      = 3'h4,
      EMS_RESP_RAMP      = 3'h5,
      EMS_RESP_FAST      = 3'h6,
      EMS_RESP_DCINJ     = 3'h7
   } ems_resp_t;

   typedef enum logic [1:0] {
      EMS_DRV_OTHER = 2'h0,
      EMS_DRV_READY = 2'h1,
      EMS_DRV_RUN   = 2'h2
   } ems_drv_t;

   typedef enum logic [2:0] {
      EMS_STOP_NONE      = 3'h0,
      EMS_STOP_RAMP      = 3'h1,
      EMS_STOP_FAST      = 3'h2,
      EMS_STOP_FREEWHEEL = 3'h3,
      EMS_STOP_DCINJ     = 3'h4
   } ems_stop_t;

   typedef enum logic [1:0] {
      EMS_CH_IDLE,
      EMS_CH_WAIT,
      EMS_CH_ACT
   } ems_chst_t;

endpackage

// ===== verilog/ems_sync.sv
// Purpose: three-stage synchroniser for pin inputs
// Assumes: d_in is asynchronous to clk
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
module ems_sync import ems_pkg::*; #(
   parameter int W = 6
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] d_out
);
   logic [W-1:0] s1_q, s2_q, s3_q, out_q;
   logic [W-1:0] out_d;

   always_comb begin
      out_d = out_q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            out_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         out_q <= '0;
      end else begin
         s1_q  <= d_in;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         out_q <= out_d;
      end
   end

   assign d_out = out_q;
endmodule // ems_sync

// ===== verilog/ems_tick.sv
// Purpose: one-cycle enable pulse every COUNT clocks
// Assumes: COUNT at least 1
// Notes:   free running, not aligned to any channel event
`timescale 1ns/1ps
module ems_tick import ems_pkg::*; #(
   parameter int unsigned COUNT = 200000000
) (
   input  wire logic clk,
   input  wire logic rst_b,
   output logic      tick
);
   logic [31:0] cnt_d, cnt_q;
   logic        tick_d, tick_q;

   always_comb begin
      tick_d = (cnt_q == COUNT - 32'd1);
      cnt_d  = tick_d ? 32'h00000000 : cnt_q + 32'h00000001;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q  <= 32'h00000000;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule // ems_tick

// ===== verilog/ems_top.sv
// Purpose: four-channel supervisor of external monitoring inputs of a motor drive
// Assumes: drive_state, run_cmd and cmd_bits come from logic on clk; din from pins
// Notes:   responses are requests to the drive; the drive carries them out
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "ems_cfg.svh"
module ems_top import ems_pkg::*; #(
   parameter int unsigned SEC_CYCLES = `EMS_STEP_S * `EMS_CLK_HZ
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic [1:0]  drive_state,
   input  wire logic        run_cmd,
   input  wire logic [5:0]  din,
   input  wire logic [15:0] cmd_bits,
   output logic      [3:0]  channel_warning_flag,
   output logic      [3:0]  channel_error_flag,
   output logic             stop_req,
   output logic      [2:0]  stop_kind,
   output logic             fallback_req,
   output logic      [15:0] fallback_speed,
   output logic             hold_req
);

   // ****************************************************************
   // reset release and shared timing
   // ****************************************************************
   logic rst_s1_q, rst_sync_b;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_q   <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_s1_q   <= 1'b1;
         rst_sync_b <= rst_s1_q;
      end
   end

   logic [5:0] din_s;
   logic       sec_tick;

   ems_sync #(
      .W     (6)
   ) u_din_sync (
      .clk   (clk),
      .rst_b (rst_sync_b),
      .d_in  (din),
      .d_out (din_s)
   );

   // delay has one second of phase uncertainty: the tick runs free
   ems_tick #(
      .COUNT (SEC_CYCLES)
   ) u_sec_tick (
      .clk   (clk),
      .rst_b (rst_sync_b),
      .tick  (sec_tick)
   );

   // ****************************************************************
   // global registers
   // ****************************************************************
   ems_stop_t   gstop_d, gstop_q;
   logic [15:0] fbspd_d, fbspd_q;
   logic        wr_ctrl, wr_stat, wr_fbspd;
   logic [2:0]  wr_stop_code;

   always_comb begin
      wr_ctrl      = reg_wr && (reg_addr == `EMS_OFF_CTRL);
      wr_stat      = reg_wr && (reg_addr == `EMS_OFF_STAT);
      wr_fbspd     = reg_wr && (reg_addr == `EMS_OFF_FBSPD);
      wr_stop_code = reg_wdata[2:0];
      gstop_d      = gstop_q;
      fbspd_d      = fbspd_q;
      if (wr_ctrl) begin
         // codes without a stop meaning fall back to ramp
         if (wr_stop_code == 3'(EMS_STOP_NONE) || wr_stop_code > 3'(EMS_STOP_DCINJ)) begin
            gstop_d = EMS_STOP_RAMP;
         end else begin
            gstop_d = ems_stop_t'(wr_stop_code);
         end
      end
      if (wr_fbspd) begin
         fbspd_d = reg_wdata[15:0];
      end
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         gstop_q <= ems_stop_t'(`EMS_STOPK_RST);
         fbspd_q <= `EMS_FBSPD_RST;
      end else begin
         gstop_q <= gstop_d;
         fbspd_q <= fbspd_d;
      end
   end

   // ****************************************************************
   // channels
   // ****************************************************************
   logic [3:0]  ch_err, ch_warn, ch_act, ch_wait, ch_asg, ch_fb, ch_hold;
   logic [2:0]  ch_kind [4];
   logic [31:0] ch_cfg_rd [4];
   logic [31:0] ch_tmr_rd [4];

   for (genvar i = 0; i < 4; i++) begin : g_ch
      logic [5:0] sel_d, sel_q, new_sel;
      ems_gate_t  gate_d, gate_q;
      ems_resp_t  resp_d, resp_q;
      logic [8:0] dly_d, dly_q, new_dly;
      logic [8:0] cnt_d, cnt_q;
      ems_chst_t  st_d, st_q;
      logic       err_d, err_q, warn_d, warn_q;
      logic       assigned, raw, gate_ok, cond, wr_hit, fire, stopping;

      // input selection and drive-state gating
      always_comb begin
         assigned = (sel_q != `EMS_SEL_NONE);
         raw      = 1'b0;
         if (sel_q >= `EMS_SEL_DIH_LO && sel_q <= `EMS_SEL_DIH_HI) begin
            raw = din_s[3'(sel_q - `EMS_SEL_DIH_LO)];
         end else if (sel_q >= `EMS_SEL_DIL_LO && sel_q <= `EMS_SEL_DIL_HI) begin
            raw = ~din_s[3'(sel_q - `EMS_SEL_DIL_LO)];
         end else if (sel_q >= `EMS_SEL_CMD_LO) begin
            raw = cmd_bits[4'(sel_q - `EMS_SEL_CMD_LO)];
         end
         case (gate_q)
            EMS_GATE_ALWAYS:    gate_ok = 1'b1;
            EMS_GATE_READY_RUN: gate_ok = (drive_state == EMS_DRV_READY) ||
                                          (drive_state == EMS_DRV_RUN);
            EMS_GATE_RUN:       gate_ok = (drive_state == EMS_DRV_RUN);
            default:            gate_ok = 1'b1;
         endcase
         cond = assigned && gate_ok && raw;
      end

      // configuration writes
      always_comb begin
         wr_hit  = reg_wr && (reg_addr == 4'(`EMS_OFF_CHAN + i));
         new_sel = reg_wdata[`EMS_F_SEL_LSB +: 6];
         new_dly = reg_wdata[`EMS_F_DLY_LSB +: 9];
         sel_d   = sel_q;
         gate_d  = gate_q;
         resp_d  = resp_q;
         dly_d   = dly_q;
         if (new_sel > `EMS_SEL_DIL_HI && new_sel < `EMS_SEL_CMD_LO) begin
            new_sel = `EMS_SEL_NONE;
         end
         if (new_dly > `EMS_DLY_MAX_S) begin
            new_dly = `EMS_DLY_MAX_S;
         end
         if (wr_hit) begin
            sel_d = new_sel;
            // settings only land when the same write selects an input
            if (new_sel != `EMS_SEL_NONE) begin
               gate_d = ems_gate_t'(reg_wdata[`EMS_F_GATE_LSB +: 2]);
               resp_d = ems_resp_t'(reg_wdata[`EMS_F_RESP_LSB +: 3]);
               dly_d  = new_dly;
            end
         end
      end

      // delay and response sequencing
      always_comb begin
         st_d  = st_q;
         cnt_d = cnt_q;
         case (st_q)
            EMS_CH_IDLE: begin
               cnt_d = 9'h000;
               if (cond) begin
                  st_d = (dly_q == 9'h000) ? EMS_CH_ACT : EMS_CH_WAIT;
               end
            end
            EMS_CH_WAIT: begin
               if (!cond) begin
                  st_d  = EMS_CH_IDLE;
                  cnt_d = 9'h000;
               end else if (sec_tick) begin
                  cnt_d = 9'(cnt_q + 9'h001);
                  if (9'(cnt_q + 9'h001) >= dly_q) begin
                     st_d = EMS_CH_ACT;
                  end
               end
            end
            EMS_CH_ACT: begin
               if (!cond) begin
                  st_d  = EMS_CH_IDLE;
                  cnt_d = 9'h000;
               end
            end
            default: begin
               st_d  = EMS_CH_IDLE;
               cnt_d = 9'h000;
            end
         endcase
         if (!assigned) begin
            st_d  = EMS_CH_IDLE;
            cnt_d = 9'h000;
         end
      end

      // flags and per-channel requests
      always_comb begin
         fire     = (st_d == EMS_CH_ACT) && (st_q != EMS_CH_ACT);
         stopping = (resp_q == EMS_RESP_FREEWHEEL) || (resp_q == EMS_RESP_RAMP) ||
                    (resp_q == EMS_RESP_FAST) || (resp_q == EMS_RESP_DCINJ);
         err_d    = err_q;
         if (wr_stat && reg_wdata[i]) begin
            err_d = 1'b0;
         end
         // set wins over a clear in the same cycle
         if (fire && stopping) begin
            err_d = 1'b1;
         end
         warn_d = (st_d == EMS_CH_ACT) && (resp_q == EMS_RESP_IGNORE);
      end

      always_ff @(posedge clk or negedge rst_sync_b) begin
         if (!rst_sync_b) begin
            sel_q  <= `EMS_SEL_NONE;
            gate_q <= ems_gate_t'(`EMS_GATE_RST);
            resp_q <= ems_resp_t'(`EMS_RESP_RST);
            dly_q  <= `EMS_DLY_RST;
            cnt_q  <= 9'h000;
            st_q   <= EMS_CH_IDLE;
            err_q  <= 1'b0;
            warn_q <= 1'b0;
         end else begin
            sel_q  <= sel_d;
            gate_q <= gate_d;
            resp_q <= resp_d;
            dly_q  <= dly_d;
            cnt_q  <= cnt_d;
            st_q   <= st_d;
            err_q  <= err_d;
            warn_q <= warn_d;
         end
      end

      // stop kind wanted by this channel; error stops hold until cleared
      always_comb begin
         ch_kind[i] = EMS_STOP_NONE;
         if (err_q) begin
            case (resp_q)
               EMS_RESP_FREEWHEEL: ch_kind[i] = EMS_STOP_FREEWHEEL;
               EMS_RESP_RAMP:      ch_kind[i] = EMS_STOP_RAMP;
               EMS_RESP_FAST:      ch_kind[i] = EMS_STOP_FAST;
               EMS_RESP_DCINJ:     ch_kind[i] = EMS_STOP_DCINJ;
               default:            ch_kind[i] = EMS_STOP_NONE;
            endcase
         end else if (st_q == EMS_CH_ACT && resp_q == EMS_RESP_PER_STOP) begin
            ch_kind[i] = gstop_q;
         end
      end

      assign ch_err[i]  = err_q;
      assign ch_warn[i] = warn_q;
      assign ch_act[i]  = (st_q == EMS_CH_ACT);
      assign ch_wait[i] = (st_q == EMS_CH_WAIT);
      assign ch_asg[i]  = assigned;
      assign ch_fb[i]   = (st_q == EMS_CH_ACT) && (resp_q == EMS_RESP_FALLBACK) &&
                          cond && run_cmd;
      assign ch_hold[i] = (st_q == EMS_CH_ACT) && (resp_q == EMS_RESP_HOLD) &&
                          cond && run_cmd;
      // hidden fields read as zero while unassigned
      assign ch_cfg_rd[i] = assigned ?
                            ((32'(dly_q) << `EMS_F_DLY_LSB) |
                             (32'(resp_q) << `EMS_F_RESP_LSB) |
                             (32'(gate_q) << `EMS_F_GATE_LSB) |
                             (32'(sel_q) << `EMS_F_SEL_LSB)) : 32'h00000000;
      assign ch_tmr_rd[i] = (32'(ch_wait[i]) << `EMS_F_WAIT_BIT) | 32'(cnt_q);
   end

   // ****************************************************************
   // response merge and outputs
   // ****************************************************************
   // stop severity: freewheel over injection over fast over ramp
   function automatic logic [2:0] stop_rank(input logic [2:0] k);
      case (ems_stop_t'(k))
         EMS_STOP_FREEWHEEL: stop_rank = 3'h4;
         EMS_STOP_DCINJ:     stop_rank = 3'h3;
         EMS_STOP_FAST:      stop_rank = 3'h2;
         EMS_STOP_RAMP:      stop_rank = 3'h1;
         default:            stop_rank = 3'h0;
      endcase
   endfunction

   logic [2:0]  kind_d, kind_q;
   logic        stop_d, stop_q, fb_d, fb_q, hold_d, hold_q;

   always_comb begin
      kind_d = EMS_STOP_NONE;
      for (int k = 0; k < 4; k++) begin
         if (stop_rank(ch_kind[k]) > stop_rank(kind_d)) begin
            kind_d = ch_kind[k];
         end
      end
      stop_d = (kind_d != 3'(EMS_STOP_NONE));
      // a stop overrides any speed-keeping response
      fb_d   = (|ch_fb) && !stop_d;
      hold_d = (|ch_hold) && !stop_d && !fb_d;
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         kind_q <= EMS_STOP_NONE;
         stop_q <= 1'b0;
         fb_q   <= 1'b0;
         hold_q <= 1'b0;
      end else begin
         kind_q <= kind_d;
         stop_q <= stop_d;
         fb_q   <= fb_d;
         hold_q <= hold_d;
      end
   end

   // ****************************************************************
   // read port
   // ****************************************************************
   logic [31:0] rdata_d, rdata_q;

   always_comb begin
      rdata_d = 32'h00000000;
      if (reg_rd) begin
         case (reg_addr)
            4'h0, 4'h1, 4'h2, 4'h3: rdata_d = ch_cfg_rd[2'(reg_addr - `EMS_OFF_CHAN)];
            `EMS_OFF_CTRL:          rdata_d = 32'(gstop_q);
            `EMS_OFF_STAT:          rdata_d = 32'(ch_err) |
                                              (32'(ch_warn) << `EMS_ST_WARN_LSB) |
                                              (32'(ch_act) << `EMS_ST_ACT_LSB) |
                                              (32'(ch_asg) << 12);
            `EMS_OFF_FBSPD:         rdata_d = 32'(fbspd_q);
            4'h8, 4'h9, 4'hA, 4'hB: rdata_d = ch_tmr_rd[2'(reg_addr - `EMS_OFF_TIMER)];
            default:                rdata_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         rdata_q <= 32'h00000000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata            = rdata_q;
   assign channel_warning_flag = ch_warn;
   assign channel_error_flag   = ch_err;
   assign stop_req             = stop_q;
   assign stop_kind            = kind_q;
   assign fallback_req         = fb_q;
   assign fallback_speed       = fbspd_q;
   assign hold_req             = hold_q;

endmodule // ems_top
